// *** rtl/burst_if.sv ***
// Burst sequence carrier between the core and the order generator
`timescale 1ns/1ps
interface burst_if;
  logic [2:0] start_low;
  logic [1:0] beat_pair;
  logic [2:0] len_mask;
  logic       interleave;
  logic [2:0] off_even;
  logic [2:0] off_odd;

  modport order_gen (
    input  start_low,
    input  beat_pair,
    input  len_mask,
    input  interleave,
    output off_even,
    output off_odd
  );

  modport core (
    output start_low,
    output beat_pair,
    output len_mask,
    output interleave,
    input  off_even,
    input  off_odd
  );
endinterface : burst_if

// *** rtl/burst_order.sv ***
// Column offset generator for the two beats of one core word
`timescale 1ns/1ps
module burst_order (
  burst_if.order_gen bus
);

  // Offset inside the block; masking keeps the burst wrapping in place
  function automatic logic [2:0] beat_offset(
    input logic [2:0] start,
    input logic [2:0] beat,
    input logic [2:0] mask,
    input logic       il
  );
    logic [2:0] raw;
    raw = il ? (start ^ beat) : 3'(start + beat); // RULE_23
    return raw & mask; // RULE_22
  endfunction : beat_offset

  // Even beat goes out on the first half, odd beat on the second
  assign bus.off_even = beat_offset(bus.start_low, {bus.beat_pair, 1'b0}, bus.len_mask,
                                    bus.interleave); // RULE_17
  assign bus.off_odd  = beat_offset(bus.start_low, {bus.beat_pair, 1'b1}, bus.len_mask,
                                    bus.interleave); // RULE_17

endmodule : burst_order

// *** rtl/ddr_device_core.sv ***
// DDR device core: command decode, mode registers, burst engine, storage
// Notes on behaviour
// RULE_01 - Core moves one double-width word per clock, pins carry two halves.
// RULE_02 - Active command opens the row given by address in the selected bank.
// RULE_03 - Column bits with Read or Write give the burst start column.
// RULE_04 - Controller waits 200 us after power and clock are stable.
// RULE_05 - Data and strobe outputs stay undriven until a read drives them.
// RULE_06 - Controller then applies NOP, raises clock enable, precharges all banks.
// RULE_07 - Controller enables DLL via extended register, then sets mode with DLL reset.
// RULE_08 - Two hundred NOP clocks follow DLL reset before any executable command.
// RULE_09 - After lock cycles a precharge all leaves all banks idle.
// RULE_10 - Controller performs two auto refreshes while idle.
// RULE_11 - Controller rewrites mode with DLL reset cleared, then operation starts.
// RULE_12 - Mode set with bank select zero loads the config register, kept until rewritten.
// RULE_13 - DLL reset bit eight clears itself; other mode bits stay.
// RULE_14 - Bits 0-2 length, 3 order, 4-6 latency, 7-12 operating setting.
// RULE_15 - Controller loads mode only with banks idle, then waits.
// RULE_16 - Length codes 1, 2, 3 mean two, four, eight; others reserved.
// RULE_17 - Order bit zero is sequential, one is interleaved.
// RULE_18 - Latency codes 2, 3, 6 mean 2, 3, 2.5 clocks; 5 optional 1.5. Core rounds 2.5 up to 3 and 1.5 up to 2.
// RULE_19 - Operating setting zero is normal, two requests DLL reset.
// RULE_20 - Mode bits are write-only with no read-back path.
// RULE_21 - Programmed length governs both read and write bursts.
// RULE_22 - Burst stays inside an aligned block of its length and wraps.
// RULE_23 - Sequential order adds beat count, interleaved XORs it with start.
// RULE_24 - Read taken at edge n drives first data at edge n plus latency.
// RULE_25 - Mode set with bank select one loads extended register; bit 0 low enables DLL.
// RULE_26 - Controller should refuse reserved length, latency or operating codes.
`timescale 1ns/1ps
module ddr_device_core
  import ddr_pkg::*;
#(
  parameter int DQ_W     = 8,
  parameter int COL_W    = 10,
  parameter int ROW_KEEP = 2
)(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [1:0]        bank_select_bits,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [2*DQ_W-1:0] dq_in,
  input  wire logic [1:0]        dm_in,
  output logic      [2*DQ_W-1:0] dq_out,
  output logic                   dq_oe,
  output logic      [1:0]        dqs_out,
  output logic                   dqs_oe
);

  localparam int MEM_AW = 2 + ROW_KEEP + COL_W;

  typedef struct packed {
    logic [ADDR_W-1:0]                 operating_config_register;
    logic [ADDR_W-1:0]                 ext;
    logic [NUM_BANKS-1:0]              open;
    logic [NUM_BANKS-1:0][ADDR_W-1:0]  rows;
    logic                              busy;
    logic                              is_rd;
    logic [1:0]                        bank;
    logic [COL_W-1:0]                  start_col;
    logic [2:0]                        len_mask;
    logic                              interleave;
    logic [1:0]                        beat;
    logic [LAT_W-1:0]                  lat_cnt;
    logic [2*DQ_W-1:0]                 dq;
    logic                              oe;
    logic [1:0]                        dqs;
  } core_state_type;

  core_state_type    st_ff;
  core_state_type    nxt_st;
  cmd_type           cmd;
  logic              rw_ok;
  logic              rd_take;
  logic              wr_take;
  logic              xfer;
  logic              xfer_rd;
  logic              mrs_main;
  logic              mrs_ext;
  logic [COL_W-1:0]  col_even;
  logic [COL_W-1:0]  col_odd;
  logic [2*DQ_W-1:0] rd_word;
  logic [DQ_W-1:0]   mem [0:(1 << MEM_AW)-1];

  burst_if bif ();

  // Column inside the aligned block; upper bits never change in a burst
  function automatic logic [COL_W-1:0] block_col(
    input logic [COL_W-1:0] start,
    input logic [2:0]       mask,
    input logic [2:0]       off
  );
    block_col = start;
    block_col[2:0] = (start[2:0] & ~mask) | off; // RULE_22
  endfunction : block_col

  // Storage index; only a few row bits are kept to bound the model size
  function automatic logic [MEM_AW-1:0] mem_idx(
    input logic [1:0]       bank,
    input logic [ADDR_W-1:0] row,
    input logic [COL_W-1:0] col
  );
    return {bank, row[ROW_KEEP-1:0], col};
  endfunction : mem_idx

  // Command decode; burst stop and NOP both do nothing here
  always_comb
  begin
    cmd = CMD_NOP;
    if (!cs_n)
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h0:    cmd = CMD_MRS;
        3'h1:    cmd = CMD_REF;
        3'h2:    cmd = CMD_PRE;
        3'h3:    cmd = CMD_ACT;
        3'h4:    cmd = CMD_WR;
        3'h5:    cmd = CMD_RD;
        default: cmd = CMD_NOP;
      endcase
    end
  end

  // Accept conditions; bursts are not interruptible, so a busy core ignores new ones
  assign rw_ok    = cke && !st_ff.busy && st_ff.open[bank_select_bits];
  assign rd_take  = rw_ok && cmd == CMD_RD && !st_ff.ext[EXT_DLL_BIT]; // RULE_25
  assign wr_take  = rw_ok && cmd == CMD_WR;
  assign mrs_main = cke && cmd == CMD_MRS && bank_select_bits == BA_MODE; // RULE_12
  assign mrs_ext  = cke && cmd == CMD_MRS && bank_select_bits == BA_EXT; // RULE_25
  assign xfer     = cke && st_ff.busy && st_ff.lat_cnt == LAT_ONE;
  assign xfer_rd  = xfer && st_ff.is_rd;

  // Beat ordering comes from the generator
  assign bif.start_low  = st_ff.start_col[2:0];
  assign bif.beat_pair  = st_ff.beat;
  assign bif.len_mask   = st_ff.len_mask;
  assign bif.interleave = st_ff.interleave;

  burst_order u_order (
    .bus (bif.order_gen)
  );

  assign col_even = block_col(st_ff.start_col, st_ff.len_mask, bif.off_even);
  assign col_odd  = block_col(st_ff.start_col, st_ff.len_mask, bif.off_odd);
  // Two columns fetched per clock, even column in the low half
  assign rd_word  = {mem[mem_idx(st_ff.bank, st_ff.rows[st_ff.bank], col_odd)],
                     mem[mem_idx(st_ff.bank, st_ff.rows[st_ff.bank], col_even)]}; // RULE_01

  // Next state; clock enable low freezes everything
  always_comb
  begin
    nxt_st = st_ff;
    if (cke)
    begin
      nxt_st.oe  = 1'b0;
      nxt_st.dqs = 2'h0;
      nxt_st.dq  = '0;
      // Self clear only for the DLL reset setting; test modes keep their bits
      if (st_ff.operating_config_register[OP_LSB +: 6] == OP_DLL_RST)
        nxt_st.operating_config_register[DLL_RST_BIT] = 1'b0; // RULE_13 RULE_19
      if (st_ff.busy && st_ff.lat_cnt > LAT_ONE)
        nxt_st.lat_cnt = st_ff.lat_cnt - LAT_ONE; // RULE_24
      else if (st_ff.busy)
      begin
        nxt_st.oe  = st_ff.is_rd; // RULE_05
        nxt_st.dqs = st_ff.is_rd ? DQS_PAIR : 2'h0;
        nxt_st.dq  = st_ff.is_rd ? rd_word : '0;
        if (st_ff.beat == st_ff.len_mask[2:1])
          nxt_st.busy = 1'b0; // RULE_21
        else
          nxt_st.beat = st_ff.beat + 2'h1;
      end
      unique case (cmd)
        CMD_MRS:
        begin
          if (mrs_main)
            nxt_st.operating_config_register = addr; // RULE_12
          else if (mrs_ext)
            nxt_st.ext = addr; // RULE_25
        end
        CMD_ACT:
        begin
          nxt_st.open[bank_select_bits] = 1'b1; // RULE_02
          nxt_st.rows[bank_select_bits] = addr; // RULE_02
        end
        CMD_PRE:
        begin
          if (addr[PRE_ALL_BIT])
            nxt_st.open = '0; // RULE_09
          else
            nxt_st.open[bank_select_bits] = 1'b0;
        end
        CMD_RD, CMD_WR:
        begin
          if (rd_take || wr_take)
          begin
            nxt_st.busy       = 1'b1;
            nxt_st.is_rd      = rd_take;
            nxt_st.bank       = bank_select_bits;
            nxt_st.start_col  = addr[COL_W-1:0]; // RULE_03
            nxt_st.len_mask   = len_mask_of(st_ff.operating_config_register[BL_LSB +: 3]); // RULE_14 RULE_16 RULE_21
            nxt_st.interleave = st_ff.operating_config_register[BT_BIT]; // RULE_17
            nxt_st.beat       = 2'h0;
            nxt_st.lat_cnt    = rd_take ? lat_of(st_ff.operating_config_register[CL_LSB +: 3])
                                        : LAT_ONE; // RULE_18 RULE_24
          end
        end
        CMD_NOP, CMD_REF: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '{operating_config_register: MODE_RST, ext: EXT_RST, default: '0};
    else
      st_ff <= nxt_st;
  end

  // Write beats land one clock after the command; mask bit high skips a half
  always_ff @(posedge sys_clk)
  begin
    if (xfer && !st_ff.is_rd)
    begin
      if (!dm_in[0])
        mem[mem_idx(st_ff.bank, st_ff.rows[st_ff.bank], col_even)] <= dq_in[DQ_W-1:0]; // RULE_01
      if (!dm_in[1])
        mem[mem_idx(st_ff.bank, st_ff.rows[st_ff.bank], col_odd)] <= dq_in[2*DQ_W-1:DQ_W];
    end
  end

  // Pins show only burst data, never the mode bits
  assign dq_out  = st_ff.dq; // RULE_20
  assign dq_oe   = st_ff.oe; // RULE_05
  assign dqs_out = st_ff.dqs;
  assign dqs_oe  = st_ff.oe;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_lat2;
    rd_take && lat_of(st_ff.operating_config_register[CL_LSB +: 3]) == 2'h2;
  endsequence
  sequence s_rd_lat3;
    rd_take && lat_of(st_ff.operating_config_register[CL_LSB +: 3]) == 2'h3;
  endsequence
  sequence s_dll_rst_load;
    mrs_main && addr[OP_LSB +: 6] == OP_DLL_RST;
  endsequence

  property p_core_pair;
    xfer_rd |=> dq_oe && dqs_out == DQS_PAIR && dq_out == $past(rd_word);
  endproperty
  a_core_pair: assert property (p_core_pair) else $error("read word not on pins"); // RULE_01

  property p_act_row;
    (cke && cmd == CMD_ACT) |=> st_ff.open[$past(bank_select_bits)]
                                && st_ff.rows[$past(bank_select_bits)] == $past(addr);
  endproperty
  a_act_row: assert property (p_act_row) else $error("active did not open row"); // RULE_02

  property p_start_col;
    (rd_take || wr_take) |=> st_ff.busy && st_ff.start_col == $past(addr[COL_W-1:0]);
  endproperty
  a_start_col: assert property (p_start_col) else $error("start column not taken"); // RULE_03

  property p_hiz;
    $rose(dq_oe) |-> $past(xfer_rd);
  endproperty
  a_hiz: assert property (p_hiz) else $error("data driven without read"); // RULE_05

  property p_mode_load;
    mrs_main |=> st_ff.operating_config_register == $past(addr) && $stable(st_ff.ext);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("mode register not loaded"); // RULE_12

  property p_dll_clear;
    s_dll_rst_load ##1 (cke && cmd != CMD_MRS) |=>
      !st_ff.operating_config_register[DLL_RST_BIT] && $stable(st_ff.operating_config_register[7:0]);
  endproperty
  a_dll_clear: assert property (p_dll_clear) else $error("DLL reset bit stuck"); // RULE_13

  property p_ext_load;
    mrs_ext |=> st_ff.ext == $past(addr) && $stable(st_ff.operating_config_register[7:0]);
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("extended register not loaded"); // RULE_25

  property p_lat2;
    s_rd_lat2 ##1 cke[*2] |=> dq_oe;
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency two data late"); // RULE_24

  property p_lat3;
    s_rd_lat3 ##1 cke[*2] |=> !dq_oe ##1 ($past(cke) ? dq_oe : 1'b1);
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency three data off time"); // RULE_24

  property p_len8;
    ($rose(dq_oe) && st_ff.len_mask == 3'h7 && cke) ##1 cke[*3] |-> dq_oe ##1 !dq_oe;
  endproperty
  a_len8: assert property (p_len8) else $error("eight beat burst wrong length"); // RULE_21

  property p_block;
    st_ff.busy |-> col_odd[COL_W-1:3] == st_ff.start_col[COL_W-1:3]
                   && (col_odd[2:0] & ~st_ff.len_mask) == (st_ff.start_col[2:0] & ~st_ff.len_mask);
  endproperty
  a_block: assert property (p_block) else $error("burst left its block"); // RULE_22

  property p_interleave;
    st_ff.busy && st_ff.interleave |->
      bif.off_even == ((st_ff.start_col[2:0] ^ {st_ff.beat, 1'b0}) & st_ff.len_mask);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong"); // RULE_23

endmodule : ddr_device_core

// *** rtl/ddr_pkg.sv ***
// Shared constants, command codes and mode decoders for the DDR device core
package ddr_pkg;

  localparam int ADDR_W    = 13;
  localparam int NUM_BANKS = 4;
  localparam int LAT_W     = 2;

  // Bank select values that pick a mode register during a mode set
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT  = 2'h1;

  // Field positions inside the operating config register, the extended register and the precharge address
  localparam int BL_LSB      = 0;
  localparam int BT_BIT      = 3;
  localparam int CL_LSB      = 4;
  localparam int OP_LSB      = 7;
  localparam int DLL_RST_BIT = 8;
  localparam int EXT_DLL_BIT = 0;
  localparam int PRE_ALL_BIT = 10;

  // Field codes
  localparam logic [2:0] BL2        = 3'h1;
  localparam logic [2:0] BL4        = 3'h2;
  localparam logic [2:0] BL8        = 3'h3;
  localparam logic [2:0] CL2        = 3'h2;
  localparam logic [2:0] CL3        = 3'h3;
  localparam logic [2:0] CL15       = 3'h5;
  localparam logic [2:0] CL25       = 3'h6;
  localparam logic [5:0] OP_NORMAL  = 6'h00;
  localparam logic [5:0] OP_DLL_RST = 6'h02;

  // Values after reset, latency step and strobe pattern; DLL stays off until the extended register enables it
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_RST  = 13'h0001;
  localparam logic [LAT_W-1:0]  LAT_ONE  = 2'h1;
  localparam logic [1:0]        DQS_PAIR = 2'h1;

  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE, CMD_ACT, CMD_WR, CMD_RD} cmd_type;

  // Burst length code to column wrap mask; reserved codes act as two
  function automatic logic [2:0] len_mask_of(input logic [2:0] code);
    unique case (code)
      BL4:     return 3'h7 >> 1;
      BL8:     return 3'h7;
      default: return 3'h1;
    endcase
  endfunction : len_mask_of

  // Read latency code to whole clocks; half clocks round up
  function automatic logic [LAT_W-1:0] lat_of(input logic [2:0] code);
    unique case (code)
      CL2, CL15: return 2'h2;
      default:   return 2'h3;
    endcase
  endfunction : lat_of

endpackage : ddr_pkg

// *** sim/ddr_ctrl_model.sv ***
// Behavioural memory controller driving the device command and data pins
`timescale 1ns/1ps
module ddr_ctrl_model
  import ddr_pkg::*;
#(
  parameter int DQ_W      = 8,
  parameter int PWR_WAIT  = 20000,
  parameter int LOCK_WAIT = 200
)(
  input  wire logic         sys_clk,
  output logic              cke,
  output logic              cs_n,
  output logic              ras_n,
  output logic              cas_n,
  output logic              we_n,
  output logic [1:0]        bank_select_bits,
  output logic [ADDR_W-1:0] addr,
  output logic [2*DQ_W-1:0] dq_in,
  output logic [1:0]        dm_in
);
  // Pin codes for {ras_n, cas_n, we_n}
  localparam logic [2:0] P_MRS    = 3'h0;
  localparam logic [2:0] P_REF    = 3'h1;
  localparam logic [2:0] P_PRE    = 3'h2;
  localparam logic [2:0] P_ACT    = 3'h3;
  localparam logic [2:0] P_WR     = 3'h4;
  localparam logic [2:0] P_RD     = 3'h5;
  localparam logic [3:0] NOP_PINS = 4'h7;
  // Deselect carrying a mode-set code; chip select alone must keep it harmless
  localparam logic [3:0] DESEL_PINS = 4'h8;

  // Quiet pins; clock enable stays low through the power-up wait
  initial
  begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = NOP_PINS;
    bank_select_bits = 2'h0;
    addr = 13'h0000;
    dq_in = '0;
    dm_in = 2'h0;
  end

  // Data lines flip on every command or idle clock so a stale value never passes for write data
  task automatic cmd(input logic [2:0] code, input logic [1:0] ba, input logic [ADDR_W-1:0] a);
    @(negedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} = {1'b0, code};
    bank_select_bits = ba;
    addr = a;
    dq_in = ~dq_in;
  endtask : cmd

  task automatic idle(input int n);
    repeat (n)
    begin
      @(negedge sys_clk);
      {cs_n, ras_n, cas_n, we_n} = DESEL_PINS;
      dq_in = ~dq_in;
    end
  endtask : idle

  // One core word with its two mask bits, high bit skips that half
  task automatic data(input logic [2*DQ_W-1:0] word, input logic [1:0] mask);
    @(negedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} = NOP_PINS;
    dq_in = word;
    dm_in = mask;
  endtask : data

  task automatic act(input logic [1:0] ba, input logic [ADDR_W-1:0] row);
    cmd(P_ACT, ba, row);
  endtask : act

  task automatic rd(input logic [1:0] ba, input logic [ADDR_W-1:0] a);
    cmd(P_RD, ba, a);
  endtask : rd

  task automatic wr(input logic [1:0] ba, input logic [ADDR_W-1:0] a);
    cmd(P_WR, ba, a);
  endtask : wr

  task automatic pre_bank(input logic [1:0] ba);
    cmd(P_PRE, ba, 13'h0000);
  endtask : pre_bank

  // Banks are closed first: mode loads are only legal with all banks idle
  task automatic ext(input logic [ADDR_W-1:0] a);
    cmd(P_PRE, 2'h0, 13'h0400);
    cmd(P_MRS, BA_EXT, a);
    idle(1);
  endtask : ext

  task automatic set_mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
                          input logic dll_rst);
    if (!(bl inside {BL2, BL4, BL8}) || !(cl inside {CL2, CL3, CL15, CL25}))
      return;
    cmd(P_PRE, 2'h0, 13'h0400);
    cmd(P_MRS, BA_MODE, {4'h0, dll_rst, 1'b0, cl, bt, bl});
    idle(dll_rst ? LOCK_WAIT : 1);
  endtask : set_mode

  // Full power-up order, ending with the DLL reset bit cleared
  task automatic power_up(input logic [ADDR_W-1:0] mode);
    idle(PWR_WAIT);
    @(negedge sys_clk);
    cke = 1'b1;
    idle(1);
    cmd(P_PRE, 2'h0, 13'h0400);
    cmd(P_MRS, BA_EXT, 13'h0000);
    cmd(P_MRS, BA_MODE, mode | 13'h0100);
    idle(LOCK_WAIT);
    cmd(P_PRE, 2'h0, 13'h0400);
    cmd(P_REF, 2'h0, 13'h0000);
    cmd(P_REF, 2'h0, 13'h0000);
    cmd(P_MRS, BA_MODE, mode);
    idle(2);
  endtask : power_up
endmodule : ddr_ctrl_model

// *** sim/ddr_sdram_init_mode_register_tb.sv ***
// Self-checking bench: init order, mode fields, burst order and read latency
`timescale 1ns/1ps
module ddr_sdram_init_mode_register_tb;
  import ddr_pkg::*;

  localparam int DQ_W  = 8;
  localparam int COL_W = 10;

  logic              sys_clk;
  logic              rst_n;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [1:0]        bank_select_bits;
  logic [ADDR_W-1:0] addr;
  logic [2*DQ_W-1:0] dq_in;
  logic [1:0]        dm_in;
  logic [2*DQ_W-1:0] dq_out;
  logic              dq_oe;
  logic [1:0]        dqs_out;
  logic              dqs_oe;
  int                n_errors;
  int                checked;
  int                seed;
  logic              rd_window;
  logic [2:0]        cur_bl;
  logic              cur_bt;
  logic [2:0]        cur_cl;
  logic [DQ_W-1:0]   exp_mem [4][1024];
  logic [ADDR_W-1:0] rows [4];

  // Free-running 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  ddr_device_core #(.DQ_W(DQ_W), .COL_W(COL_W), .ROW_KEEP(2)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select_bits(bank_select_bits), .addr(addr),
    .dq_in(dq_in), .dm_in(dm_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe)
  );

  ddr_ctrl_model #(.DQ_W(DQ_W)) i_ctrl (
    .sys_clk(sys_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_select_bits(bank_select_bits), .addr(addr), .dq_in(dq_in),
    .dm_in(dm_in)
  );

  // Column of beat b; a slip in wrap or order shows as wrong data
  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] start, input int b);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] bb;
    mask = (cur_bl == BL8) ? 10'h007 : (cur_bl == BL4) ? 10'h003 : 10'h001;
    bb = b[COL_W-1:0];
    return (start & ~mask) | ((cur_bt ? (start ^ bb) : (start + bb)) & mask);
  endfunction : col_of

  task automatic expect_eq(input logic [19:0] got, input logic [19:0] exp_v, input string what);
    checked++;
    if (got !== exp_v)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp_v);
    end
  endtask : expect_eq

  // Pins must stay undriven whenever no read is in flight
  always @(negedge sys_clk)
    if (rst_n === 1'b1 && !rd_window && (dq_oe !== 1'b0 || dqs_oe !== 1'b0))
    begin
      n_errors++;
      $display("[ERR] %0t output driven outside a read", $time);
    end

  // Samples twelve clocks after the command; live low means the read must be ignored
  task automatic read_check(input logic [1:0] ba, input logic [COL_W-1:0] start,
                            input logic live);
    int m;
    int w;
    int k;
    logic [19:0] exp_v;
    m = (cur_cl == CL2 || cur_cl == CL15) ? 2 : 3;
    w = 1 << (cur_bl - 3'h1);
    rd_window = 1'b1;
    i_ctrl.rd(ba, {3'h0, start});
    for (int i = 0; i < 12; i++)
    begin
      i_ctrl.idle(1);
      k = i - m;
      exp_v = 20'h0_0000;
      if (live && k >= 0 && k < w)
        exp_v = {2'h3, DQS_PAIR, exp_mem[ba][col_of(start, 2*k+1)], exp_mem[ba][col_of(start, 2*k)]};
      expect_eq({dq_oe, dqs_oe, dqs_out, dq_out}, exp_v, "read beat");
    end
    rd_window = 1'b0;
  endtask : read_check

  // Writes a whole block from its first column; masked halves keep older data
  task automatic write_block(input logic [1:0] ba, input logic [COL_W-1:0] base,
                             input logic masked);
    int w;
    logic [1:0] dm;
    logic [2*DQ_W-1:0] word;
    w = 1 << (cur_bl - 3'h1);
    i_ctrl.wr(ba, {3'h0, base});
    for (int k = 0; k < w; k++)
    begin
      word = (2*DQ_W)'($random(seed));
      dm = masked ? 2'($random(seed)) : 2'h0;
      if (!dm[0])
        exp_mem[ba][base + 2*k] = word[DQ_W-1:0];
      if (!dm[1])
        exp_mem[ba][base + 2*k + 1] = word[2*DQ_W-1:DQ_W];
      i_ctrl.data(word, dm);
    end
    i_ctrl.idle(1);
  endtask : write_block

  // Every mode or extended load closes all banks, so rows are reopened after it
  task automatic open_rows;
    for (int b = 0; b < 4; b++)
      i_ctrl.act(b[1:0], rows[b]);
  endtask : open_rows

  task automatic load_mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
                           input logic dll_rst);
    cur_bl = bl;
    cur_bt = bt;
    cur_cl = cl;
    i_ctrl.set_mode(bl, bt, cl, dll_rst);
    open_rows();
  endtask : load_mode

  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Hang guard
  initial
  begin
    #500000;
    n_errors++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    int w;
    logic [1:0] ba;
    logic [COL_W-1:0] base;
    logic [2:0] cl_tab [4];
    n_errors = 0;
    checked = 0;
    seed = 64;
    rd_window = 1'b0;
    rst_n = 1'b0;
    cl_tab = '{CL2, CL3, CL15, CL25};
    for (int b = 0; b < 4; b++)
      rows[b] = ADDR_W'($random(seed));
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    expect_eq({dq_oe, dqs_oe, dqs_out, dq_out}, 20'h0_0000, "quiet after reset");
    i_ctrl.power_up({6'h00, CL3, 1'b0, BL4});
    for (int a = 1; a <= 3; a++)
      for (int t = 0; t < 2; t++)
        for (int c = 0; c < 4; c++)
        begin
          load_mode(a[2:0], t[0], cl_tab[c], 1'b0);
          w = 1 << (a - 1);
          ba = 2'($random(seed));
          base = COL_W'($random(seed)) & ~COL_W'(2*w - 1);
          write_block(ba, base, 1'b0);
          read_check(ba, base | (COL_W'($random(seed)) & COL_W'(2*w - 1)), 1'b1);
          write_block(ba, base, 1'b1);
          read_check(ba, base + COL_W'(2*w - 1), 1'b1);
        end
    // Disabled DLL blocks reads; re-enabling keeps the main mode
    load_mode(BL8, 1'b1, CL25, 1'b0);
    write_block(2'h0, 10'h010, 1'b0);
    i_ctrl.ext(13'h0001);
    open_rows();
    read_check(2'h0, 10'h013, 1'b0);
    i_ctrl.ext(13'h0000);
    open_rows();
    read_check(2'h0, 10'h013, 1'b1);
    // DLL reset load keeps every other mode bit
    load_mode(BL4, 1'b0, CL2, 1'b1);
    write_block(2'h3, 10'h3fc, 1'b0);
    read_check(2'h3, 10'h3fe, 1'b1);
    load_mode(BL4, 1'b0, CL2, 1'b0);
    read_check(2'h3, 10'h3fd, 1'b1);
    // Read to a closed bank is ignored
    i_ctrl.pre_bank(2'h3);
    read_check(2'h3, 10'h3fc, 1'b0);
    wrap_up();
  end
endmodule : ddr_sdram_init_mode_register_tb
